// *** psms_asserts.sv ***
// Purpose: Port checks for psms_top
// Assumes: One clock, async high reset
// Notes: Bound at the foot of this file
`timescale 1ns/1ps
module psms_asserts
  import psms_pkg::*;
#(
  parameter int PRESS_CYCLES = PRESS_CYC,
  parameter int GLITCH_CYCLES = GLITCH_CYC
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_supply_good_in,
  input wire logic i_main_supply_low,
  input wire logic i_watchdog_timeout,
  input wire logic i_sw_reset_req,
  input wire logic i_mgmt_bus_alert_n,
  input wire logic i_alert_irq_en,
  input wire logic i_cpu_thermal_trip,
  input wire logic i_sleep_req,
  input wire logic o_carrier_reset_out_n,
  input wire logic o_low_power_pending_n,
  input wire logic o_suspend_ram_n,
  input wire logic o_suspend_disk_n,
  input wire logic o_soft_off_n,
  input wire logic o_thermal_shutdown_out_n,
  input wire logic o_mgmt_interrupt
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  logic [8:0] rlow_r;
  logic [8:0] alow_r;
  // Reset low with no level source must end after one pulse
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) rlow_r <= '0;
    else if (o_carrier_reset_out_n || !i_supply_good_in || i_main_supply_low
             || i_watchdog_timeout || i_sw_reset_req) rlow_r <= '0;
    else rlow_r <= rlow_r + 9'h001;
  end
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) alow_r <= '0;
    else if (i_mgmt_bus_alert_n || !i_alert_irq_en) alow_r <= '0;
    else if (alow_r != 9'h1FF) alow_r <= alow_r + 9'h001;
  end
  sequence s_on;
    o_low_power_pending_n && o_suspend_ram_n && o_suspend_disk_n;
  endsequence
  sequence s_entered;
    $fell(o_suspend_ram_n) or $fell(o_suspend_disk_n);
  endsequence
  property p_pend_start;
    s_on ##0 i_sleep_req |=> !o_low_power_pending_n;
  endproperty
  a_pend_start: assert property (p_pend_start)
    else $error("no pending after sleep request");
  property p_pend_first;
    s_entered |-> !$past(o_low_power_pending_n);
  endproperty
  a_pend_first: assert property (p_pend_first)
    else $error("sleep state without pending");
  property p_same_off;
    o_suspend_disk_n == o_soft_off_n;
  endproperty
  a_same_off: assert property (p_same_off)
    else $error("disk and off outputs differ");
  property p_supply;
    !i_supply_good_in || i_main_supply_low |-> ##[1:4] !o_carrier_reset_out_n;
  endproperty
  a_supply: assert property (p_supply)
    else $error("no carrier reset on bad supply");
  property p_rst_len;
    rlow_r <= RST_CYC + 8;
  endproperty
  a_rst_len: assert property (p_rst_len)
    else $error("carrier reset held too long");
  property p_therm;
    !$past(i_reset) |-> o_thermal_shutdown_out_n == !$past(i_cpu_thermal_trip);
  endproperty
  a_therm: assert property (p_therm)
    else $error("thermal shutdown output wrong");
  property p_irq_on;
    alow_r > GLITCH_CYCLES + 6 |-> o_mgmt_interrupt;
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("alert gave no interrupt");
  property p_irq_en;
    o_mgmt_interrupt |-> $past(i_alert_irq_en);
  endproperty
  a_irq_en: assert property (p_irq_en)
    else $error("interrupt while disabled");
endmodule : psms_asserts
bind psms_top psms_asserts #(.PRESS_CYCLES(PRESS_CYCLES),
  .GLITCH_CYCLES(GLITCH_CYCLES)) u_chk (.i_mclk, .i_reset,
  .i_supply_good_in, .i_main_supply_low, .i_watchdog_timeout,
  .i_sw_reset_req, .i_mgmt_bus_alert_n, .i_alert_irq_en,
  .i_cpu_thermal_trip, .i_sleep_req, .o_carrier_reset_out_n,
  .o_low_power_pending_n, .o_suspend_ram_n, .o_suspend_disk_n,
  .o_soft_off_n, .o_thermal_shutdown_out_n, .o_mgmt_interrupt);

// *** psms_carrier.sv ***
// Purpose: Carrier buttons, sensors and supply
// Assumes: Released pins sit at the pull-up level
// Notes: Pins change 1 ns after the clock edge
`timescale 1ns/1ps
module psms_carrier
  import psms_pkg::*;
(
  input wire logic i_mclk,
  output logic [NUM_IN-1:0] o_pins_n,
  output logic o_supply_good
);
  // ****
  // Pins
  // ****
  logic [NUM_IN-1:0] low_r = '0;
  logic bad_r = 1'b0;
  assign o_pins_n = ~low_r;
  assign o_supply_good = ~bad_r;
  // Press length is the caller's, 16 ms maps to PRESS_CYCLES
  task automatic hold(input int ix, input int cyc);
    @(posedge i_mclk) #1 low_r[ix] = 1'b1;
    repeat (cyc) @(posedge i_mclk);
    #1 low_r[ix] = 1'b0;
  endtask : hold
  task automatic supply(input logic good);
    @(posedge i_mclk) #1 bad_r = ~good;
  endtask : supply
endmodule : psms_carrier

// *** psms_pkg.sv ***
// Purpose: Constants and types for power and system management signals
// Assumes: 200 MHz standby clock, inputs synchronous to it
// Notes: Event pulses go to the system-side controller
//
// Summary of operation
// - A power button low for 16 ms brings the system out of soft-off.
// - The reset button is edge triggered and never holds reset while low.
// - Button, bad supply, low input, watchdog or software pull carrier reset.
// - Pending-low-power goes low shortly before a low-power state.
// - Suspend-to-RAM output is low while the system is in suspend-to-RAM.
// - Suspend-to-disk and soft-off share one signal, low in either state.
// - A low PCI Express wake request input asks the system to wake.
// - A low general purpose wake input asks the system to wake.
// - A low battery-weak input is reported as a status.
// - A cover switch low for 16 ms is reported as a lid event.
// - A doze button low for 16 ms is reported as a sleep event.
// - A low over-temperature input is treated as a thermal event.
// - Thermal shutdown goes low once the processor is in thermal shutdown.
// - A low management bus alert can raise a management interrupt.
package psms_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 200;
  localparam int PRESS_MS = 16;
  localparam int PRESS_CYC = PRESS_MS * 1000 * CLK_MHZ;
  localparam int GLITCH_NS = 1000;
  localparam int GLITCH_CYC = GLITCH_NS * CLK_MHZ / 1000;
  localparam int PEND_NS = 1000;
  localparam int PEND_CYC = PEND_NS * CLK_MHZ / 1000;
  localparam int RST_NS = 1000;
  localparam int RST_CYC = RST_NS * CLK_MHZ / 1000;
  localparam int NUM_IN = 9;
  // Input index positions
  localparam int IX_PWRB = 0;
  localparam int IX_RSTB = 1;
  localparam int IX_PCIW = 2;
  localparam int IX_GENW = 3;
  localparam int IX_BATT = 4;
  localparam int IX_LID = 5;
  localparam int IX_DOZE = 6;
  localparam int IX_TEMP = 7;
  localparam int IX_ALRT = 8;

  typedef enum logic [4:0] {
    PSMS_ON = 5'h01,
    PSMS_PEND = 5'h02,
    PSMS_RAM = 5'h04,
    PSMS_DISK = 5'h08,
    PSMS_OFF = 5'h10
  } psms_state_type;

  typedef enum logic [1:0] {
    PSMS_TGT_RAM = 2'h0,
    PSMS_TGT_DISK = 2'h1,
    PSMS_TGT_OFF = 2'h2
  } psms_target_type;

  typedef struct packed {
    logic power_button;
    logic reset_button;
    logic pcie_wake;
    logic general_wake;
    logic lid;
    logic doze;
    logic overtemp;
  } psms_event_type;

  typedef struct packed {
    logic battery_weak;
    logic overtemp;
    logic alert;
    logic supply_good;
  } psms_status_type;
endpackage : psms_pkg

// *** psms_top.sv ***
// Purpose: Power/system management pin logic of a module
// Assumes: All pins synchronous to i_mclk; active-low pins pulled up
// Notes: Event outputs are one-cycle pulses toward system firmware
`timescale 1ns/1ps
module psms_top
  import psms_pkg::*;
#(
  parameter int PRESS_CYCLES = PRESS_CYC,
  parameter int GLITCH_CYCLES = GLITCH_CYC
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_power_button_in_n,
  input wire logic i_reset_button_in_n,
  input wire logic i_supply_good_in,
  input wire logic i_main_supply_low,
  input wire logic i_watchdog_timeout,
  input wire logic i_sw_reset_req,
  input wire logic i_pcie_rouse_req_n,
  input wire logic i_general_rouse_req_n,
  input wire logic i_battery_weak_n,
  input wire logic i_lid_in_n,
  input wire logic i_doze_in_n,
  input wire logic i_overtemp_in_n,
  input wire logic i_mgmt_bus_alert_n,
  input wire logic i_alert_irq_en,
  input wire logic i_cpu_thermal_trip,
  input wire logic i_sleep_req,
  input wire logic [1:0] i_sleep_target,
  output logic o_carrier_reset_out_n,
  output logic o_low_power_pending_n,
  output logic o_suspend_ram_n,
  output logic o_suspend_disk_n,
  output logic o_soft_off_n,
  output logic o_thermal_shutdown_out_n,
  output logic o_mgmt_interrupt,
  output psms_event_type o_events,
  output psms_status_type o_status
);
  localparam int PW = $clog2(PRESS_CYCLES + 2);
  localparam int PCW = $clog2(PEND_CYC + 1);
  localparam int RCW = $clog2(RST_CYC + 1);

  // ****************************************
  // Input synchronisers and filters
  // ****************************************
  logic [NUM_IN-1:0] raw_in;
  logic [NUM_IN-1:0] sync1_r;
  logic [NUM_IN-1:0] sync2_r;
  logic [NUM_IN-1:0] filt_low_r;
  logic [NUM_IN-1:0] long_low_r;
  logic [NUM_IN-1:0] long_low_d_r;

  assign raw_in = {i_mgmt_bus_alert_n, i_overtemp_in_n, i_doze_in_n,
                   i_lid_in_n, i_battery_weak_n, i_general_rouse_req_n,
                   i_pcie_rouse_req_n, i_reset_button_in_n,
                   i_power_button_in_n};

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      sync1_r <= '1;
      sync2_r <= '1;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
    end
  end

  // Short filter for level inputs, press counter for button inputs
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_filt
      logic [PW-1:0] cnt_r;
      always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
          cnt_r <= '0;
          filt_low_r[gi] <= 1'b0;
          long_low_r[gi] <= 1'b0;
        end else begin
          if (sync2_r[gi]) begin
            cnt_r <= '0;
          end else if (cnt_r != PW'(PRESS_CYCLES)) begin
            cnt_r <= cnt_r + PW'(1);
          end
          // Glitches shorter than the filter never reach the system
          filt_low_r[gi] <= (cnt_r >= PW'(GLITCH_CYCLES));
          long_low_r[gi] <= (cnt_r >= PW'(PRESS_CYCLES) - PW'(1));
        end
      end
    end
  endgenerate

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      long_low_d_r <= '0;
    end else begin
      long_low_d_r <= long_low_r;
    end
  end

  // Rising edge of qualified press: one event per press
  logic [NUM_IN-1:0] press_evt;
  logic [NUM_IN-1:0] filt_low_d_r;
  assign press_evt = long_low_r & ~long_low_d_r;

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      filt_low_d_r <= '0;
    end else begin
      filt_low_d_r <= filt_low_r;
    end
  end

  // ****************************************
  // Sleep state machine
  // ****************************************
  psms_state_type state_r;
  psms_state_type state_nxt;
  logic [1:0] target_r;
  logic [PCW-1:0] pend_cnt_r;
  logic rouse;

  assign rouse = press_evt[IX_PCIW] | press_evt[IX_GENW]
               | (filt_low_r[IX_PCIW] & ~filt_low_d_r[IX_PCIW])
               | (filt_low_r[IX_GENW] & ~filt_low_d_r[IX_GENW]);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PSMS_ON: begin
        if (i_sleep_req) begin
          state_nxt = PSMS_PEND;
        end
      end
      PSMS_PEND: begin
        // Pending warning lasts PEND_CYC + 1 cycles before the state is entered
        if (pend_cnt_r == '0) begin
          unique case (target_r)
            2'h0: state_nxt = PSMS_RAM;
            2'h1: state_nxt = PSMS_DISK;
            default: state_nxt = PSMS_OFF;
          endcase
        end
      end
      PSMS_RAM, PSMS_DISK: begin
        if (rouse || press_evt[IX_PWRB] || press_evt[IX_DOZE]) begin
          state_nxt = PSMS_ON;
        end
      end
      PSMS_OFF: begin
        // Only the power button or a wake request leave soft-off
        if (press_evt[IX_PWRB] || rouse) begin
          state_nxt = PSMS_ON;
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      state_r <= PSMS_ON;
      target_r <= PSMS_TGT_RAM;
      pend_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (state_r == PSMS_ON && i_sleep_req) begin
        target_r <= i_sleep_target;
        pend_cnt_r <= PCW'(PEND_CYC);
      end else if (pend_cnt_r != '0) begin
        pend_cnt_r <= pend_cnt_r - PCW'(1);
      end
    end
  end

  // ****************************************
  // Carrier reset
  // ****************************************
  // Reset button only starts a fixed pulse, so a stuck button cannot hold it
  logic [RCW-1:0] rst_cnt_r;
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      rst_cnt_r <= '0;
    end else if (press_evt[IX_RSTB] || i_watchdog_timeout
                 || i_sw_reset_req) begin
      rst_cnt_r <= RCW'(RST_CYC);
    end else if (rst_cnt_r != '0) begin
      rst_cnt_r <= rst_cnt_r - RCW'(1);
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_carrier_reset_out_n <= 1'b0;
    end else begin
      // Supply-good low means power not good: hold reset
      o_carrier_reset_out_n <= ~((rst_cnt_r != '0) || press_evt[IX_RSTB]
        || !i_supply_good_in || i_main_supply_low
        || i_watchdog_timeout || i_sw_reset_req);
    end
  end

  // ****************************************
  // State outputs
  // ****************************************
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_low_power_pending_n <= 1'b1;
      o_suspend_ram_n <= 1'b1;
      o_suspend_disk_n <= 1'b1;
      o_soft_off_n <= 1'b1;
    end else begin
      o_low_power_pending_n <= (state_nxt != PSMS_PEND);
      o_suspend_ram_n <= (state_nxt != PSMS_RAM);
      // One common level drives both pins
      o_suspend_disk_n <= !(state_nxt == PSMS_DISK
                            || state_nxt == PSMS_OFF);
      o_soft_off_n <= !(state_nxt == PSMS_DISK
                        || state_nxt == PSMS_OFF);
    end
  end

  // ****************************************
  // Thermal, alert and reporting
  // ****************************************
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_thermal_shutdown_out_n <= 1'b1;
      o_mgmt_interrupt <= 1'b0;
      o_events <= '0;
      o_status <= '0;
    end else begin
      o_thermal_shutdown_out_n <= !i_cpu_thermal_trip;
      o_mgmt_interrupt <= i_alert_irq_en & filt_low_r[IX_ALRT];
      o_events.power_button <= press_evt[IX_PWRB];
      o_events.reset_button <= press_evt[IX_RSTB];
      o_events.pcie_wake <= filt_low_r[IX_PCIW] & ~filt_low_d_r[IX_PCIW];
      o_events.general_wake <= filt_low_r[IX_GENW] & ~filt_low_d_r[IX_GENW];
      o_events.lid <= press_evt[IX_LID];
      o_events.doze <= press_evt[IX_DOZE];
      o_events.overtemp <= filt_low_r[IX_TEMP] & ~filt_low_d_r[IX_TEMP];
      o_status.battery_weak <= filt_low_r[IX_BATT];
      o_status.overtemp <= filt_low_r[IX_TEMP];
      o_status.alert <= filt_low_r[IX_ALRT];
      o_status.supply_good <= i_supply_good_in;
    end
  end
endmodule : psms_top

// *** test_psms_top.sv ***
// Purpose: Self-checking bench for psms_top
// Assumes: Short press and glitch counts
// Notes: Carrier model drives the pins
`timescale 1ns/1ps
module test_psms_top
  import psms_pkg::*;
;
  // ****
  // Bench
  // ****
  localparam int P = 50;
  logic clk, rst, mlow, wdog, swr, aen, trip, sreq;
  logic [1:0] stgt;
  wire logic [NUM_IN-1:0] pins_n;
  wire logic good;
  logic cr_n, pend_n, ram_n, disk_n, off_n, thr_n, irq;
  psms_event_type ev, ev_seen;
  psms_status_type st;
  int mismatches = 0;
  int tests_run = 0;
  wire logic [4:0] mon = {cr_n, pend_n, ram_n, disk_n, off_n};
  psms_carrier carrier (.i_mclk(clk), .o_pins_n(pins_n), .o_supply_good(good));
  psms_top #(.PRESS_CYCLES(P), .GLITCH_CYCLES(4)) uut (.i_mclk(clk),
    .i_reset(rst), .i_power_button_in_n(pins_n[IX_PWRB]),
    .i_reset_button_in_n(pins_n[IX_RSTB]), .i_supply_good_in(good),
    .i_main_supply_low(mlow), .i_watchdog_timeout(wdog),
    .i_sw_reset_req(swr), .i_pcie_rouse_req_n(pins_n[IX_PCIW]),
    .i_general_rouse_req_n(pins_n[IX_GENW]),
    .i_battery_weak_n(pins_n[IX_BATT]), .i_lid_in_n(pins_n[IX_LID]),
    .i_doze_in_n(pins_n[IX_DOZE]), .i_overtemp_in_n(pins_n[IX_TEMP]),
    .i_mgmt_bus_alert_n(pins_n[IX_ALRT]), .i_alert_irq_en(aen),
    .i_cpu_thermal_trip(trip), .i_sleep_req(sreq), .i_sleep_target(stgt),
    .o_carrier_reset_out_n(cr_n), .o_low_power_pending_n(pend_n),
    .o_suspend_ram_n(ram_n), .o_suspend_disk_n(disk_n), .o_soft_off_n(off_n),
    .o_thermal_shutdown_out_n(thr_n), .o_mgmt_interrupt(irq), .o_events(ev),
    .o_status(st));
  always @(posedge clk) ev_seen <= ev_seen | ev;
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // Every wait is bounded, a hang ends the run
  task automatic wt(input int i, input logic v, input int n);
    int k;
    for (k = 0; k < n && mon[i] !== v; k++) tick(1);
    if (mon[i] !== v) begin
      mismatches++;
      $display("MISMATCH %0t timeout", $time);
      end_sim();
    end
  endtask : wt
  task automatic t_sleep;
    int k;
    int src;
    logic [1:0] tg;
    logic [7:0] want;
    for (k = 0; k < 6; k++) begin
      tg = (k == 4) ? 2'h0 : 2'(k);
      stgt = tg;
      sreq = 1'b1;
      tick(1);
      sreq = 1'b0;
      chk(8'(pend_n), 8'h00, "pending");
      wt(tg == 2'h0 ? 2 : 1, 1'b0, 400);
      want = 8'({2'h3, tg != 2'h0, {2{tg == 2'h0}}});
      chk(8'(mon), want, "state");
      if (k == 3) begin
        carrier.hold(IX_PWRB, P - 10);
        tick(20);
        chk(8'(off_n), 8'h00, "short press");
        // Doze button must not leave soft-off
        carrier.hold(IX_DOZE, P + 10);
        tick(20);
        chk(8'(off_n), 8'h00, "doze in off");
      end
      ev_seen = '0;
      src = k == 0 ? IX_GENW : k == 4 ? IX_PCIW : k == 5 ? IX_DOZE : IX_PWRB;
      want = k == 0 ? 8'h08 : k == 4 ? 8'h10 : k == 5 ? 8'h02 : 8'h40;
      carrier.hold(src, P + 10);
      wt(2, 1'b1, 100);
      wt(1, 1'b1, 100);
      chk(8'(ev_seen), want, "wake");
    end
    $display("sleep test done");
  endtask : t_sleep
  task automatic t_carrier;
    int j;
    for (j = 0; j < 4; j++) begin
      wdog = (j == 0);
      swr = (j == 1);
      mlow = (j == 3);
      if (j == 2) carrier.supply(1'b0);
      tick(1);
      wdog = 1'b0;
      swr = 1'b0;
      tick(30);
      chk(8'(cr_n), 8'h00, "carrier reset");
      if (j == 2) chk(8'(st.supply_good), 8'h00, "supply status");
      mlow = 1'b0;
      if (j == 2) carrier.supply(1'b1);
      wt(4, 1'b1, 300);
    end
    $display("carrier test done");
  endtask : t_carrier
  task automatic t_reset_btn;
    logic [7:0] got;
    ev_seen = '0;
    fork
      carrier.hold(IX_RSTB, P + 400);
    join_none
    wt(4, 1'b0, P + 20);
    wt(4, 1'b1, 300);
    got = 8'({ev_seen.reset_button, pins_n[IX_RSTB]});
    chk(got, 8'h02, "button");
    wait fork;
    $display("reset button test done");
  endtask : t_reset_btn
  task automatic t_status;
    // Low shorter than the glitch filter must not show
    carrier.hold(IX_BATT, 2);
    tick(10);
    chk(8'(st), 8'h01, "glitch");
    ev_seen = '0;
    aen = 1'b1;
    trip = 1'b1;
    fork
      carrier.hold(IX_BATT, P + 10);
      carrier.hold(IX_TEMP, P + 10);
      carrier.hold(IX_ALRT, P + 10);
      carrier.hold(IX_LID, P + 10);
      carrier.hold(IX_DOZE, P + 10);
    join_none
    tick(30);
    chk(8'({st, irq, thr_n}), 8'h3E, "status");
    wait fork;
    trip = 1'b0;
    tick(12);
    chk(8'(ev_seen), 8'h07, "events");
    chk(8'({st, irq, thr_n}), 8'h05, "status idle");
    $display("status test done");
  endtask : t_status
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    {rst, mlow, wdog, swr, aen, trip, sreq, stgt} = 9'h100;
    ev_seen = '0;
    repeat (20) @(posedge clk);
    chk(8'(mon), 8'h0F, "reset values");
    #1 rst = 1'b0;
    tick(4);
    t_sleep();
    t_carrier();
    t_reset_btn();
    t_status();
    end_sim();
  end
endmodule : test_psms_top
